/* hcr_handler.sv */
// hub class request decode and execution over the default control pipe
`timescale 1ns/10ps
module hcr_handler (
	// clock and bus reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// setup stage
	input wire logic i_setup_valid,
	input wire hcr_pkg::hcr_setup_s i_setup,
	// completion
	output logic o_done,
	output logic o_stall,
	output logic o_pass,
	// in data stage
	output logic o_tx_valid,
	output logic [7:0] o_tx_data,
	output logic o_tx_last,
	input wire logic i_tx_ready,
	// port state
	input wire logic [hcr_pkg::NPORTS-1:0] i_port_suspended,
	input wire logic [hcr_pkg::NPORTS-1:0] i_port_powered,
	input wire hcr_pkg::hcr_chg_s [hcr_pkg::NPORTS-1:0] i_port_event,
	output hcr_pkg::hcr_chg_s [hcr_pkg::NPORTS-1:0] o_port_change,
	// port actions
	output logic [hcr_pkg::NPORTS-1:0] o_port_disable,
	output logic [hcr_pkg::NPORTS-1:0] o_port_resume,
	output logic [hcr_pkg::NPORTS-1:0] o_port_power_off,
	output logic [hcr_pkg::NPORTS-1:0] o_port_ind_off,
	output logic [7:0] o_ind_selector,
	// translator buffer clear
	output logic o_tt_clear,
	output hcr_pkg::hcr_tt_s o_tt_buf,
	// hub status pins and change word
	input wire logic i_local_power_lost,
	input wire logic i_hub_oc,
	input wire logic i_oc_hub_mode,
	input wire logic [15:0] i_hub_change,
	output logic [15:0] o_hub_status_word
);
	import hcr_pkg::*;

	typedef enum logic [1:0] {ST_IDLE, ST_EXEC, ST_LOAD, ST_SEND} hcr_state_e;

	hcr_state_e state_q;
	hcr_setup_s setup_q;
	logic [7:0] port_num;
	logic [NPORTS-1:0] port_hot;
	logic port_ok, tt_port_ok, sel_def;
	logic is_pfc, is_ttc, is_gd, is_gs, claimed;
	logic pfc_err, ttc_err, gd_err, gs_err, req_err;
	logic in_exec, pfc_go, ttc_go, send_go;
	logic [7:0] gd_len;
	logic [2:0] pins_s;
	logic lp_s, oc_s, mode_s;
	logic [15:0] status_d, status_q;
	logic [NPORTS-1:0] disable_q, resume_q, power_off_q, ind_off_q;
	logic [7:0] ind_sel_q;
	logic tt_clear_q;
	hcr_tt_s tt_buf_q;
	logic done_q, stall_q, pass_q;
	logic [31:0] payload_q;
	logic src_desc_q;
	logic [7:0] send_len_q, idx_q, nxt_idx;
	logic tx_valid_q, tx_last_q;
	logic [7:0] tx_data_q;
	logic tx_hs;
	hcr_chg_s [NPORTS-1:0] change_q;

	function automatic logic [7:0] byte_at(input logic [7:0] i,
		input logic d, input logic [31:0] pl);
		logic [7:0] b;
		b = 8'h00;
		if (d) begin
			if (i < DESC_LEN_B) begin
				b = DESC_ROM[i[3:0]];
			end
		end else begin
			b = pl[{i[1:0], 3'b000} +: 8];
		end
		return b;
	endfunction

	// hub pins arrive from outside the clock domain
	hcr_sync #(.W(3)) u_pin_sync (
		.i_sys_clk(i_sys_clk),
		.i_rstn(i_rstn),
		.i_async({i_oc_hub_mode, i_hub_oc, i_local_power_lost}),
		.o_sync(pins_s)
	);
	assign lp_s = pins_s[0];
	assign oc_s = pins_s[1];
	assign mode_s = pins_s[2];

	always_comb begin
		status_d = STATUS_RESET;
		status_d[LOCAL_PWR_BIT] = lp_s;
		status_d[HUB_OC_BIT] = oc_s & mode_s;
	end

	// reserved bits stay at their zero reset value
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			status_q <= STATUS_RESET;
		end else begin
			status_q <= status_d;
		end
	end

	// a setup arriving while busy is dropped; the pipe sends one at a time
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			setup_q <= '0;
		end else if (state_q == ST_IDLE && i_setup_valid) begin
			setup_q <= i_setup;
		end
	end

	// port number in the low index byte
	assign port_num = setup_q.index[7:0];
	assign port_ok = (port_num != 8'h00) && (port_num <= 8'(NPORTS));

	// port feature clear recognised by type and code
	assign is_pfc = setup_q.req_type == TYPE_PORT_OUT &&
		setup_q.request == REQ_CLEAR_FEATURE;
	assign is_ttc = setup_q.req_type == TYPE_PORT_OUT &&
		setup_q.request == REQ_CLEAR_TT_BUF;
	assign is_gd = setup_q.req_type == TYPE_HUB_IN &&
		setup_q.request == REQ_GET_DESC;
	assign is_gs = setup_q.req_type == TYPE_HUB_IN &&
		setup_q.request == REQ_GET_STATUS;
	assign claimed = is_pfc | is_ttc | is_gd | is_gs;

	// every defined port selector is known
	always_comb begin
		case (setup_q.value)
			SEL_CONNECTION, SEL_ENABLE, SEL_SUSPEND, SEL_OVER_CURRENT,
			SEL_RESET, SEL_POWER, SEL_LOW_SPEED, SEL_C_CONNECTION,
			SEL_C_ENABLE, SEL_C_SUSPEND, SEL_C_OVER_CURRENT, SEL_C_RESET,
			SEL_TEST, SEL_INDICATOR: sel_def = 1'b1;
			default: sel_def = 1'b0;
		endcase
	end

	assign pfc_err = !sel_def || !port_ok || setup_q.length != ZERO16;
	// single translator is addressed as one
	assign tt_port_ok = TT_PER_PORT ? port_ok :
		(setup_q.index == TT_SINGLE_INDEX);
	assign ttc_err = !tt_port_ok || setup_q.length != ZERO16;
	// only the hub descriptor at index zero
	assign gd_err = setup_q.value != {DESC_TYPE, DESC_INDEX} ||
		setup_q.index != ZERO16;
	assign gs_err = setup_q.value != ZERO16 || setup_q.index != ZERO16 ||
		setup_q.length != STATUS_LEN;
	assign req_err = (is_pfc & pfc_err) | (is_ttc & ttc_err) |
		(is_gd & gd_err) | (is_gs & gs_err);

	assign gd_len = (setup_q.length > DESC_LEN_W) ? DESC_LEN_B :
		setup_q.length[7:0];

	assign in_exec = state_q == ST_EXEC;
	assign pfc_go = in_exec && is_pfc && !pfc_err;
	assign ttc_go = in_exec && is_ttc && !ttc_err;
	assign send_go = in_exec && ((is_gd && !gd_err && gd_len != 8'h00) ||
		(is_gs && !gs_err));
	assign tx_hs = tx_valid_q && i_tx_ready;

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			state_q <= ST_IDLE;
		end else begin
			case (state_q)
				ST_IDLE: begin
					if (i_setup_valid) begin
						state_q <= ST_EXEC;
					end
				end
				ST_EXEC: state_q <= send_go ? ST_LOAD : ST_IDLE;
				ST_LOAD: state_q <= ST_SEND;
				ST_SEND: begin
					if (tx_hs && tx_last_q) begin
						state_q <= ST_IDLE;
					end
				end
				default: state_q <= ST_IDLE;
			endcase
		end
	end

	// an errored request stalls and no action fires
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			done_q <= 1'b0;
			stall_q <= 1'b0;
			pass_q <= 1'b0;
		end else begin
			done_q <= (in_exec && claimed && !req_err && !send_go) ||
				(state_q == ST_SEND && tx_hs && tx_last_q);
			stall_q <= in_exec && req_err;
			pass_q <= in_exec && !claimed;
		end
	end

	// each port action is a one-cycle command to the port logic
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			disable_q <= '0;
			resume_q <= '0;
			power_off_q <= '0;
			ind_off_q <= '0;
			ind_sel_q <= 8'h00;
		end else begin
			disable_q <= (pfc_go && setup_q.value == SEL_ENABLE) ?
				(port_hot & i_port_powered) : '0;
			resume_q <= (pfc_go && setup_q.value == SEL_SUSPEND) ?
				(port_hot & i_port_suspended) : '0;
			// ganging is resolved by the power switch logic
			power_off_q <= (pfc_go && setup_q.value == SEL_POWER) ?
				port_hot : '0;
			// selector from the high index byte
			ind_off_q <= (pfc_go && setup_q.value == SEL_INDICATOR) ?
				port_hot : '0;
			if (pfc_go && setup_q.value == SEL_INDICATOR) begin
				ind_sel_q <= setup_q.index[15:8];
			end
		end
	end

	// buffer clear handed to the translator
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tt_clear_q <= 1'b0;
			tt_buf_q <= '0;
		end else begin
			tt_clear_q <= ttc_go;
			if (ttc_go) begin
				// value field split into endpoint fields
				tt_buf_q.port <= port_num;
				tt_buf_q.dir_in <= setup_q.value[TT_DIR_BIT];
				tt_buf_q.ep_type <= setup_q.value[TT_TYPE_MSB:TT_TYPE_LSB];
				tt_buf_q.dev_addr <= setup_q.value[TT_ADDR_MSB:TT_ADDR_LSB];
				tt_buf_q.ep_num <= setup_q.value[TT_EP_MSB:TT_EP_LSB];
			end
		end
	end

	for (genvar p = 0; p < NPORTS; p++) begin : g_port
		hcr_chg_s clr;
		assign port_hot[p] = port_num == 8'(p + 1);
		// the five change flags that may be cleared
		always_comb begin
			clr = '0;
			if (pfc_go && port_hot[p]) begin
				clr.conn = setup_q.value == SEL_C_CONNECTION;
				clr.enable = setup_q.value == SEL_C_ENABLE;
				clr.suspend = setup_q.value == SEL_C_SUSPEND;
				clr.over_current = setup_q.value == SEL_C_OVER_CURRENT;
				clr.reset = setup_q.value == SEL_C_RESET;
			end
		end
		// new event wins over a clear in the same cycle
		always_ff @(posedge i_sys_clk or negedge i_rstn) begin
			if (!i_rstn) begin
				change_q[p] <= '0;
			end else begin
				change_q[p] <= hcr_chg_s'((change_q[p] & ~clr) |
					i_port_event[p]);
			end
		end
	end

	// snapshot status and change in one cycle so the words agree; status goes first
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			payload_q <= '0;
			src_desc_q <= 1'b0;
			send_len_q <= 8'h00;
		end else if (send_go) begin
			payload_q <= {i_hub_change, status_q};
			src_desc_q <= is_gd;
			send_len_q <= is_gd ? gd_len : STATUS_LEN[7:0];
		end
	end

	assign nxt_idx = idx_q + 8'h01;

	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			tx_valid_q <= 1'b0;
			tx_last_q <= 1'b0;
			tx_data_q <= 8'h00;
			idx_q <= 8'h00;
		end else if (state_q == ST_LOAD) begin
			tx_valid_q <= 1'b1;
			tx_data_q <= byte_at(8'h00, src_desc_q, payload_q);
			tx_last_q <= send_len_q == 8'h01;
			idx_q <= 8'h00;
		end else if (state_q == ST_SEND && tx_hs) begin
			if (tx_last_q) begin
				tx_valid_q <= 1'b0;
				tx_last_q <= 1'b0;
			end else begin
				tx_data_q <= byte_at(nxt_idx, src_desc_q, payload_q);
				tx_last_q <= nxt_idx + 8'h01 == send_len_q;
				idx_q <= nxt_idx;
			end
		end
	end

	assign o_done = done_q;
	assign o_stall = stall_q;
	assign o_pass = pass_q;
	assign o_tx_valid = tx_valid_q;
	assign o_tx_data = tx_data_q;
	assign o_tx_last = tx_last_q;
	assign o_port_change = change_q;
	assign o_port_disable = disable_q;
	assign o_port_resume = resume_q;
	assign o_port_power_off = power_off_q;
	assign o_port_ind_off = ind_off_q;
	assign o_ind_selector = ind_sel_q;
	assign o_tt_clear = tt_clear_q;
	assign o_tt_buf = tt_buf_q;
	assign o_hub_status_word = status_q;

	default clocking cb @(posedge i_sys_clk);
	endclocking
	default disable iff (!i_rstn);

	stall_quiet_a: assert property (o_stall |->
		o_port_disable == '0 && o_port_resume == '0 && !o_tt_clear &&
		o_port_power_off == '0 && o_port_ind_off == '0 && !o_done)
		else $error("stall came with a port action");
	resume_gate_a: assert property (o_port_resume != '0 |->
		(o_port_resume & ~$past(i_port_suspended)) == '0)
		else $error("resume sent to a port that was not suspended");
	disable_gate_a: assert property (o_port_disable != '0 |->
		(o_port_disable & ~$past(i_port_powered)) == '0)
		else $error("disable sent to a powered-off port");
	one_port_a: assert property ($onehot0(o_port_disable |
		o_port_resume | o_port_power_off | o_port_ind_off))
		else $error("action reached more than one port");
	local_power_a: assert property ($past(i_rstn, 3) |->
		o_hub_status_word[LOCAL_PWR_BIT] == $past(i_local_power_lost, 3))
		else $error("local power bit does not follow the pin");
	hub_oc_a: assert property (o_hub_status_word[HUB_OC_BIT] |->
		$past(i_oc_hub_mode, 3) && $past(i_hub_oc, 3))
		else $error("hub over-current bit outside hub-wide mode");
	reserved_zero_a: assert property (
		o_hub_status_word[15:2] == 14'h0000)
		else $error("reserved status bits not zero");
	change_held_a: assert property ($past(i_port_event[0].conn) |->
		o_port_change[0].conn)
		else $error("connection change event lost");
	status_len_a: assert property (in_exec && is_gs &&
		setup_q.length != STATUS_LEN |=> o_stall)
		else $error("bad status length not stalled");
	desc_index_a: assert property (in_exec && is_gd &&
		setup_q.index != ZERO16 |=> o_stall)
		else $error("descriptor read with index not stalled");
	feat_len_a: assert property (in_exec && is_pfc &&
		setup_q.length != ZERO16 |=> o_stall)
		else $error("feature clear with length not stalled");
	tt_port_a: assert property (in_exec && is_ttc &&
		!tt_port_ok |=> o_stall && !o_tt_clear)
		else $error("buffer clear to missing port not stalled");
	tt_addr_a: assert property (o_tt_clear |->
		o_tt_buf.dev_addr == $past(setup_q.value[TT_ADDR_MSB:TT_ADDR_LSB]))
		else $error("buffer clear device address mismatch");
	status_words_a: assert property (state_q == ST_LOAD &&
		!src_desc_q |-> send_len_q == STATUS_LEN[7:0] ##1
		o_tx_data == payload_q[7:0])
		else $error("status read does not start with status word");
	desc_len_a: assert property (state_q == ST_LOAD &&
		src_desc_q |-> send_len_q <= DESC_LEN_B && send_len_q != 8'h00)
		else $error("descriptor length beyond descriptor");
	last_done_a: assert property (state_q == ST_SEND && tx_hs &&
		o_tx_last |=> o_done && !o_tx_valid)
		else $error("last byte not followed by completion");

	status_read_c: cover property (state_q == ST_SEND && !src_desc_q &&
		tx_hs && o_tx_last);
	desc_read_c: cover property (state_q == ST_SEND && src_desc_q &&
		tx_hs && o_tx_last);
	resume_c: cover property (o_port_resume != '0);
	tt_clear_c: cover property (o_tt_clear);
	stall_c: cover property (o_stall);
endmodule

/* hcr_pkg.sv */
// hub class request handler: constants, field layouts and carrier types
package hcr_pkg;
	localparam int NPORTS = 4;
	localparam logic [7:0] REQ_GET_STATUS = 8'h00;
	localparam logic [7:0] REQ_CLEAR_FEATURE = 8'h01;
	localparam logic [7:0] REQ_GET_DESC = 8'h06;
	localparam logic [7:0] REQ_CLEAR_TT_BUF = 8'h08;
	localparam logic [7:0] TYPE_PORT_OUT = 8'h23;
	localparam logic [7:0] TYPE_HUB_IN = 8'hA0;
	localparam logic [15:0] SEL_CONNECTION = 16'h0000;
	localparam logic [15:0] SEL_ENABLE = 16'h0001;
	localparam logic [15:0] SEL_SUSPEND = 16'h0002;
	localparam logic [15:0] SEL_OVER_CURRENT = 16'h0003;
	localparam logic [15:0] SEL_RESET = 16'h0004;
	localparam logic [15:0] SEL_POWER = 16'h0008;
	localparam logic [15:0] SEL_LOW_SPEED = 16'h0009;
	localparam logic [15:0] SEL_C_CONNECTION = 16'h0010;
	localparam logic [15:0] SEL_C_ENABLE = 16'h0011;
	localparam logic [15:0] SEL_C_SUSPEND = 16'h0012;
	localparam logic [15:0] SEL_C_OVER_CURRENT = 16'h0013;
	localparam logic [15:0] SEL_C_RESET = 16'h0014;
	localparam logic [15:0] SEL_TEST = 16'h0015;
	localparam logic [15:0] SEL_INDICATOR = 16'h0016;
	// buffer clear value layout
	localparam int TT_EP_LSB = 0;
	localparam int TT_EP_MSB = 3;
	localparam int TT_ADDR_LSB = 4;
	localparam int TT_ADDR_MSB = 10;
	localparam int TT_TYPE_LSB = 11;
	localparam int TT_TYPE_MSB = 12;
	localparam int TT_DIR_BIT = 15;
	localparam logic TT_PER_PORT = 1'b1;
	localparam logic [15:0] TT_SINGLE_INDEX = 16'h0001;
	// hub status word layout
	localparam int LOCAL_PWR_BIT = 0;
	localparam int HUB_OC_BIT = 1;
	localparam logic [15:0] STATUS_RESET = 16'h0000;
	localparam logic [15:0] ZERO16 = 16'h0000;
	localparam logic [15:0] STATUS_LEN = 16'h0004;
	// hub descriptor held as a constant table
	localparam int DESC_LEN = 9;
	localparam logic [7:0] DESC_LEN_B = 8'(DESC_LEN);
	localparam logic [15:0] DESC_LEN_W = 16'(DESC_LEN);
	localparam logic [7:0] DESC_TYPE = 8'h29;
	localparam logic [7:0] DESC_INDEX = 8'h00;
	localparam logic [DESC_LEN-1:0][7:0] DESC_ROM = {
		8'hFF, 8'h00, 8'h64, 8'h32, 8'h00, 8'h09,
		8'(NPORTS), DESC_TYPE, DESC_LEN_B};

	typedef struct packed {
		logic [7:0] req_type;
		logic [7:0] request;
		logic [15:0] value;
		logic [15:0] index;
		logic [15:0] length;
	} hcr_setup_s;

	typedef struct packed {
		logic conn;
		logic enable;
		logic suspend;
		logic over_current;
		logic reset;
	} hcr_chg_s;

	typedef struct packed {
		logic [7:0] port;
		logic dir_in;
		logic [1:0] ep_type;
		logic [6:0] dev_addr;
		logic [3:0] ep_num;
	} hcr_tt_s;
endpackage

/* hcr_sync.sv */
// two-stage synchroniser for asynchronous hub pins
`timescale 1ns/10ps
module hcr_sync #(
	parameter int W = 1
) (
	// clock and reset
	input wire logic i_sys_clk,
	input wire logic i_rstn,
	// levels
	input wire logic [W-1:0] i_async,
	output logic [W-1:0] o_sync
);
	logic [W-1:0] meta_q;
	logic [W-1:0] sync_q;

	// first stage feeds only the second
	always_ff @(posedge i_sys_clk or negedge i_rstn) begin
		if (!i_rstn) begin
			meta_q <= '0;
			sync_q <= '0;
		end else begin
			meta_q <= i_async;
			sync_q <= meta_q;
		end
	end

	assign o_sync = sync_q;
endmodule

/* hcr_host_model.sv */
// host-side model: issues setup packets and sinks data stage bytes
`timescale 1ns/10ps
module hcr_host_model (
	// clock
	input wire logic i_sys_clk,
	// setup stage towards the hub
	output logic o_setup_valid,
	output hcr_pkg::hcr_setup_s o_setup,
	// answer from the hub
	input wire logic i_done,
	input wire logic i_stall,
	input wire logic i_pass,
	input wire logic i_tx_valid,
	input wire logic [7:0] i_tx_data,
	input wire logic i_tx_last,
	output logic o_tx_ready
);
	import hcr_pkg::*;
	// 0 no answer yet, 1 done, 2 stall, 3 pass
	logic [1:0] res;
	int n_cyc;
	logic [8:0] rx [$];
	initial begin
		o_setup_valid = 1'b0;
		o_setup = '0;
		o_tx_ready = 1'b0;
		res = 2'd0;
		n_cyc = 0;
	end
	task automatic xfer(input hcr_setup_s s, input logic slow);
		int n;
		res = 2'd0;
		rx.delete();
		@(posedge i_sys_clk);
		#1;
		o_setup = s;
		o_setup_valid = 1'b1;
		@(posedge i_sys_clk);
		#1;
		o_setup_valid = 1'b0;
		// released bus shows the inverse, never a stale copy
		o_setup = ~s;
		for (n = 1; n < 200 && res == 2'd0; n++) begin
			@(posedge i_sys_clk);
			#1;
			// what shows now is sampled by the next edge
			n_cyc = n + 1;
			if (i_done) begin
				res = 2'd1;
			end else if (i_stall) begin
				res = 2'd2;
			end else if (i_pass) begin
				res = 2'd3;
			end
			// slow sink stalls every other cycle; idle once answered
			o_tx_ready = (res != 2'd0) ? 1'b0 : (slow ? n[0] : 1'b1);
			if (i_tx_valid && o_tx_ready) begin
				rx.push_back({i_tx_last, i_tx_data});
			end
		end
	endtask
endmodule

/* hcr_handler_tb_top.sv */
// testbench for the hub class request handler
`timescale 1ns/10ps
module hcr_handler_tb_top;
	import hcr_pkg::*;
	logic sys_clk = 1'b0;
	logic rstn = 1'b0;
	logic setup_valid, done, stall, pass, tx_valid, tx_last, tx_ready, tt_clr;
	hcr_setup_s setup;
	logic [7:0] tx_data, ind_sel;
	logic [NPORTS-1:0] susp = 4'b0010;
	logic [NPORTS-1:0] pwr = 4'b0101;
	logic [NPORTS-1:0] dis, rsm, poff, ioff;
	hcr_chg_s [NPORTS-1:0] evt = '0;
	hcr_chg_s [NPORTS-1:0] chg;
	hcr_tt_s tt_buf;
	logic lost = 1'b0;
	logic hoc = 1'b0;
	logic ocm = 1'b0;
	logic [15:0] hchg = 16'h0000;
	logic [15:0] hstat;
	int fail_count = 0;
	int checks_done = 0;
	always #5 sys_clk = ~sys_clk;
	hcr_host_model host (.i_sys_clk(sys_clk), .o_setup_valid(setup_valid),
		.o_setup(setup), .i_done(done), .i_stall(stall), .i_pass(pass),
		.i_tx_valid(tx_valid), .i_tx_data(tx_data), .i_tx_last(tx_last),
		.o_tx_ready(tx_ready));
	hcr_handler uut (.i_sys_clk(sys_clk), .i_rstn(rstn),
		.i_setup_valid(setup_valid), .i_setup(setup), .o_done(done),
		.o_stall(stall), .o_pass(pass), .o_tx_valid(tx_valid),
		.o_tx_data(tx_data), .o_tx_last(tx_last), .i_tx_ready(tx_ready),
		.i_port_suspended(susp), .i_port_powered(pwr), .i_port_event(evt),
		.o_port_change(chg), .o_port_disable(dis), .o_port_resume(rsm),
		.o_port_power_off(poff), .o_port_ind_off(ioff),
		.o_ind_selector(ind_sel), .o_tt_clear(tt_clr), .o_tt_buf(tt_buf),
		.i_local_power_lost(lost), .i_hub_oc(hoc), .i_oc_hub_mode(ocm),
		.i_hub_change(hchg), .o_hub_status_word(hstat));
	task automatic stop_test();
		$display("checks %0d mismatches %0d", checks_done, fail_count);
		if (fail_count == 0 && checks_done > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e,
		input logic [31:0] g);
		checks_done++;
		if (g !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	task automatic chk_res(input string nm, input logic [1:0] e);
		checks_done++;
		if (host.res !== e) begin
			fail_count++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, host.res);
		end
		// no answer within the bound ends the run
		if (host.res === 2'd0) begin
			stop_test();
		end
	endtask
	task automatic chk_rx(input logic [DESC_LEN-1:0][7:0] e, input int n);
		int i;
		chk("rx count", 32'(n), 32'(host.rx.size()));
		for (i = 0; i < n && i < host.rx.size(); i++) begin
			chk("rx byte", {23'h0, i == n - 1, e[i]}, {23'h0, host.rx[i]});
		end
	endtask
	task automatic req(input logic [7:0] t, input logic [7:0] r,
		input logic [15:0] v, input logic [15:0] x, input logic [15:0] l,
		input logic slow);
		hcr_setup_s s;
		s = {t, r, v, x, l};
		host.xfer(s, slow);
	endtask
	task automatic pclr(input logic [15:0] sel, input logic [15:0] x,
		input logic [1:0] e);
		req(TYPE_PORT_OUT, REQ_CLEAR_FEATURE, sel, x, ZERO16, 1'b0);
		chk_res("port clear", e);
		chk("answer cycle", 32'h2, 32'(host.n_cyc));
	endtask
	initial begin
		int p;
		int k;
		logic [3:0] b;
		logic [19:0] w;
		int lens [4];
		lens = '{0, 4, 9, 20};
		repeat (20) @(posedge sys_clk);
		#1;
		rstn = 1'b1;
		chk("status reset", 32'h0, 32'(hstat));
		chk("flags reset", 32'h0, 32'(chg));
		for (p = 0; p < 8; p++) begin
			{ocm, hoc, lost} = 3'(p);
			repeat (4) @(posedge sys_clk);
			#1;
			chk("status word", {30'h0, hoc & ocm, lost}, 32'(hstat));
		end
		hchg = 16'hA5C3;
		req(TYPE_HUB_IN, REQ_GET_STATUS, ZERO16, ZERO16, STATUS_LEN, 1'b1);
		chk_res("status read", 2'd1);
		chk_rx(72'hA5C30003, 4);
		for (p = 0; p < 3; p++) begin
			req(TYPE_HUB_IN, REQ_GET_STATUS, 16'(p == 0), 16'(p == 1),
				(p == 2) ? 16'h0002 : STATUS_LEN, 1'b0);
			chk_res("status bad", 2'd2);
		end
		for (p = 0; p < 4; p++) begin
			req(TYPE_HUB_IN, REQ_GET_DESC, {DESC_TYPE, DESC_INDEX}, ZERO16,
				16'(lens[p]), p[0]);
			chk_res("desc read", 2'd1);
			chk_rx(DESC_ROM, (lens[p] < DESC_LEN) ? lens[p] : DESC_LEN);
		end
		req(TYPE_HUB_IN, REQ_GET_DESC, {DESC_TYPE, DESC_INDEX}, 16'h0001,
			DESC_LEN_W, 1'b0);
		chk_res("desc index", 2'd2);
		for (p = 1; p <= NPORTS; p++) begin
			b = 4'(1 << (p - 1));
			pclr(SEL_SUSPEND, 16'(p), 2'd1);
			chk("resume", 32'(susp & b), 32'(rsm));
			pclr(SEL_ENABLE, 16'(p), 2'd1);
			chk("disable", 32'(pwr & b), 32'(dis));
			pclr(SEL_POWER, 16'(p), 2'd1);
			chk("power off", 32'(b), 32'(poff));
			pclr(SEL_INDICATOR, {8'(p + 4), 8'(p)}, 2'd1);
			chk("ind off", 32'(b), 32'(ioff));
			chk("ind sel", 32'(p + 4), 32'(ind_sel));
		end
		for (k = 0; k < 5; k++) begin
			p = k % NPORTS;
			w = 20'(1) << (p * 5 + 4 - k);
			@(posedge sys_clk);
			#1;
			evt = w;
			@(posedge sys_clk);
			#1;
			evt = '0;
			chk("flag set", 32'(w), 32'(chg));
			pclr(SEL_C_CONNECTION + 16'(k), k[0] ? 16'h0005 : ZERO16, 2'd2);
			req(TYPE_PORT_OUT, REQ_CLEAR_FEATURE, SEL_C_CONNECTION + 16'(k),
				16'(p + 1), 16'h0001, 1'b0);
			chk_res("clear length", 2'd2);
			chk("flag kept", 32'(w), 32'(chg));
			pclr(SEL_C_CONNECTION + 16'(k), 16'(p + 1), 2'd1);
			chk("flag cleared", 32'h0, 32'(chg));
			pclr(SEL_C_CONNECTION + 16'(k), 16'(p + 1), 2'd1);
		end
		pclr(16'h0005, 16'h0001, 2'd2);
		chk("no action", 32'h0, 32'({dis, rsm, poff, ioff}));
		pclr(16'h0017, 16'h0002, 2'd2);
		req(TYPE_PORT_OUT, REQ_CLEAR_TT_BUF, 16'h955A, 16'h0003, ZERO16, 1'b0);
		chk_res("tt clear", 2'd1);
		chk("tt pulse", 32'h1, 32'(tt_clr));
		chk("tt buf", 32'({8'h03, 1'b1, 2'b10, 7'h55, 4'hA}), 32'(tt_buf));
		for (p = 0; p < 3; p++) begin
			req(TYPE_PORT_OUT, REQ_CLEAR_TT_BUF, 16'h955A,
				(p == 0) ? ZERO16 : ((p == 1) ? 16'h0005 : 16'h0003),
				16'(p == 2), 1'b0);
			chk_res("tt bad", 2'd2);
			chk("tt no pulse", 32'h0, 32'(tt_clr));
		end
		req(TYPE_PORT_OUT, 8'h03, SEL_POWER, 16'h0001, ZERO16, 1'b0);
		chk_res("unhandled", 2'd3);
		chk("no power off", 32'h0, 32'(poff));
		stop_test();
	end
endmodule
